// ===== design/ssc_pin_mux.sv
// Sleep-time selection of the managed output pins
module ssc_pin_mux
    import ssc_pkg::*;
(
    // Configuration
    input wire logic asleep,
    input wire logic req,
    input wire logic [7:0] ctrl,
    // Normal pin logic
    input wire logic out1_val,
    input wire logic out2_val,
    input wire logic clk_out_val,
    // Next pin values
    output logic pg_out,
    output logic pg_oe,
    output logic psw_oe,
    output logic clk_out
);
    logic float_cfg;

    always_comb
    begin
        // A zero int2 or clock setting implies outputs may float
        float_cfg = ~ctrl[SSC_INT2_BIT] | ~ctrl[SSC_CLK_BIT];
        pg_out = 1'b0;
        pg_oe = ~out1_val;
        psw_oe = ~out2_val;
        clk_out = clk_out_val;
        if (asleep && !ctrl[SSC_INT1_BIT])
        begin
            pg_oe = 1'b0;
        end
        if (asleep && !ctrl[SSC_INT2_BIT])
        begin
            psw_oe = 1'b1;
        end
        if ((asleep || (req && float_cfg)) && !ctrl[SSC_CLK_BIT])
        begin
            clk_out = 1'b1;
        end
    end
endmodule : ssc_pin_mux

// ===== design/ssc_pkg.sv
// Package of constants for the sleep state controller
package ssc_pkg;
    localparam logic [7:0] SSC_SLEEP_CONTROL_OFS = 8'h17;
    localparam logic [7:0] SSC_SLEEP_CONTROL_RST = 8'h00;
    localparam int SSC_REQ_BIT = 7;
    localparam int SSC_INT1_BIT = 6;
    localparam int SSC_INT2_BIT = 5;
    localparam int SSC_PORT_BIT = 4;
    localparam int SSC_CLK_BIT = 3;
    localparam int SSC_DLY_MSB = 2;
    localparam int SSC_DLY_LSB = 0;
    localparam int SSC_DLY_W = 3;
    // Clock rate and tick rates
    localparam int SSC_CLK_HZ = 50000000;
    localparam int SSC_TICK128_HZ = 128;
    localparam int SSC_TICK256_HZ = 256;
    localparam int SSC_DIV256_CYC = SSC_CLK_HZ / SSC_TICK256_HZ;
    localparam int SSC_DIV_W = 18;
    typedef enum logic [1:0] {
        SSC_AWAKE,
        SSC_PRESLEEP,
        SSC_EXTRA,
        SSC_ASLEEP
    } ssc_state_e;
endpackage : ssc_pkg

// ===== design/ssc_sleep_ctrl.sv
// Sleep state controller: control register, pre-sleep timer, pin control
//
// Contract
// - Setting the request bit starts pre-sleep timer; expiry enters sleep.
// - Any interrupt ends sleep and clears the request bit.
// - Request sets only with counters running, wake timer armed, flags clear.
// - Floating-implied outputs go high in sleep; only clock output goes high early.
// - Int1 setting zero releases power-good pin (left to float high) in sleep.
// - Int2 setting zero holds power-switch pin low in sleep.
// - Port setting zero with request set makes serial port unavailable.
// - Clock setting zero forces clock output high in sleep.
// - Three-bit delay counts 128 Hz periods before sleep engages.
// - Delay and port setting both zero add one 256 Hz period.
module ssc_sleep_ctrl
    import ssc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Register port
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Wake preconditions
    input wire logic counters_run,
    input wire logic wake_armed,
    input wire logic any_flag,
    input wire logic irq,
    // Normal pin logic
    input wire logic out1_val,
    input wire logic out2_val,
    input wire logic clk_out_val,
    // Pins and status
    output logic power_good_int_pin_o,
    output logic power_good_int_pin_oe,
    output logic power_switch_int_pin_o,
    output logic power_switch_int_pin_oe,
    output logic clock_out_pin,
    output logic serial_port_avail,
    output logic sleeping
);
    ssc_state_e st_r;
    ssc_state_e st_nxt;
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic [SSC_DLY_W-1:0] cnt_r;
    logic [SSC_DLY_W-1:0] cnt_nxt;
    logic tick256;
    logic tick128;
    logic req_ok;
    logic set_req;
    logic pg_out;
    logic pg_oe;
    logic psw_oe;
    logic clk_o;

    function automatic logic hit(input logic [7:0] a);
        hit = (a == SSC_SLEEP_CONTROL_OFS);
    endfunction : hit

    ssc_tick_gen u_tick (
        .clk(clk),
        .arst_n(arst_n),
        .tick256(tick256),
        .tick128(tick128)
    );

    always_comb
    begin
        req_ok = counters_run & wake_armed & ~any_flag;
        set_req = reg_wr && hit(reg_addr) && reg_wdata[SSC_REQ_BIT]
            && req_ok;
        ctrl_nxt = ctrl_r;
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        if (reg_wr && hit(reg_addr))
        begin
            ctrl_nxt = reg_wdata;
            // Refused set keeps request zero
            ctrl_nxt[SSC_REQ_BIT] = set_req | (ctrl_r[SSC_REQ_BIT]
                & reg_wdata[SSC_REQ_BIT]);
        end
        case (st_r)
            SSC_AWAKE:
            begin
                if (set_req && !ctrl_r[SSC_REQ_BIT])
                begin
                    st_nxt = SSC_PRESLEEP;
                    cnt_nxt = reg_wdata[SSC_DLY_MSB:SSC_DLY_LSB];
                end
            end
            SSC_PRESLEEP:
            begin
                if (!ctrl_nxt[SSC_REQ_BIT])
                begin
                    st_nxt = SSC_AWAKE;
                end
                else if (cnt_r == '0)
                begin
                    if (!ctrl_r[SSC_PORT_BIT]
                        && ctrl_r[SSC_DLY_MSB:SSC_DLY_LSB] == '0)
                    begin
                        st_nxt = SSC_EXTRA;
                    end
                    else
                    begin
                        st_nxt = SSC_ASLEEP;
                    end
                end
                else if (tick128)
                begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            SSC_EXTRA:
            begin
                if (!ctrl_nxt[SSC_REQ_BIT])
                begin
                    st_nxt = SSC_AWAKE;
                end
                else if (tick256)
                begin
                    st_nxt = SSC_ASLEEP;
                end
            end
            SSC_ASLEEP:
            begin
                if (!ctrl_nxt[SSC_REQ_BIT])
                begin
                    st_nxt = SSC_AWAKE;
                end
            end
            default:
            begin
                st_nxt = SSC_AWAKE;
            end
        endcase
        if (irq && st_r == SSC_ASLEEP)
        begin
            ctrl_nxt[SSC_REQ_BIT] = 1'b0;
            st_nxt = SSC_AWAKE;
        end
    end

    ssc_pin_mux u_mux (
        .asleep(st_nxt == SSC_ASLEEP),
        .req(ctrl_nxt[SSC_REQ_BIT]),
        .ctrl(ctrl_nxt),
        .out1_val(out1_val),
        .out2_val(out2_val),
        .clk_out_val(clk_out_val),
        .pg_out(pg_out),
        .pg_oe(pg_oe),
        .psw_oe(psw_oe),
        .clk_out(clk_o)
    );

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_r <= SSC_AWAKE;
            ctrl_r <= SSC_SLEEP_CONTROL_RST;
            cnt_r <= '0;
            reg_rdata <= 8'h00;
            power_good_int_pin_o <= 1'b0;
            power_good_int_pin_oe <= 1'b0;
            power_switch_int_pin_o <= 1'b0;
            power_switch_int_pin_oe <= 1'b0;
            clock_out_pin <= 1'b1;
            serial_port_avail <= 1'b1;
            sleeping <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            ctrl_r <= ctrl_nxt;
            cnt_r <= cnt_nxt;
            reg_rdata <= hit(reg_addr) ? ctrl_nxt : 8'h00;
            power_good_int_pin_o <= pg_out;
            power_good_int_pin_oe <= pg_oe;
            power_switch_int_pin_o <= 1'b0;
            power_switch_int_pin_oe <= psw_oe;
            clock_out_pin <= clk_o;
            serial_port_avail <= ~(ctrl_nxt[SSC_REQ_BIT]
                & ~ctrl_nxt[SSC_PORT_BIT]);
            sleeping <= (st_nxt == SSC_ASLEEP);
        end
    end

    sequence s_set_req;
        reg_wr && hit(reg_addr) && reg_wdata[SSC_REQ_BIT] && req_ok
            && !ctrl_r[SSC_REQ_BIT];
    endsequence

    sequence s_wake_evt;
        irq && st_r == SSC_ASLEEP;
    endsequence

    sequence s_sleep_entry;
        $rose(sleeping);
    endsequence

    // Entry decided with no delay and no port setting
    sequence s_quiet_entry;
        s_sleep_entry ##0 !$past(ctrl_r[SSC_PORT_BIT])
            ##0 $past(ctrl_r[SSC_DLY_MSB:SSC_DLY_LSB]) == '0;
    endsequence

    property p_load;
        @(posedge clk) disable iff (!arst_n)
        s_set_req |=> cnt_r == $past(reg_wdata[SSC_DLY_MSB:SSC_DLY_LSB]);
    endproperty
    a_load: assert property (p_load) else $error("delay not loaded");

    property p_entry;
        @(posedge clk) disable iff (!arst_n)
        s_sleep_entry |-> $past(cnt_r) == '0;
    endproperty
    a_entry: assert property (p_entry) else $error("sleep too early");

    property p_req;
        @(posedge clk) disable iff (!arst_n)
        sleeping |-> ctrl_r[SSC_REQ_BIT];
    endproperty
    a_req: assert property (p_req) else $error("sleep w/o request");

    property p_early;
        @(posedge clk) disable iff (!arst_n)
        (ctrl_r[SSC_REQ_BIT] && !ctrl_r[SSC_CLK_BIT]) |-> clock_out_pin;
    endproperty
    a_early: assert property (p_early) else $error("clock_out_pin not high");

    property p_start;
        @(posedge clk) disable iff (!arst_n)
        s_set_req |=> st_r == SSC_PRESLEEP;
    endproperty
    a_start: assert property (p_start) else $error("no pre-sleep");

    property p_wake;
        @(posedge clk) disable iff (!arst_n)
        s_wake_evt |=> !ctrl_r[SSC_REQ_BIT] && !sleeping;
    endproperty
    a_wake: assert property (p_wake) else $error("irq left sleep");

    property p_refuse;
        @(posedge clk) disable iff (!arst_n)
        (reg_wr && hit(reg_addr) && !req_ok && !ctrl_r[SSC_REQ_BIT])
            |=> !ctrl_r[SSC_REQ_BIT] && st_r == SSC_AWAKE;
    endproperty
    a_refuse: assert property (p_refuse) else $error("bad set");

    property p_int1;
        @(posedge clk) disable iff (!arst_n)
        (sleeping && !ctrl_r[SSC_INT1_BIT]) |-> !power_good_int_pin_oe;
    endproperty
    a_int1: assert property (p_int1) else $error("pg driven");

    property p_int2;
        @(posedge clk) disable iff (!arst_n)
        (sleeping && !ctrl_r[SSC_INT2_BIT]) |-> power_switch_int_pin_oe;
    endproperty
    a_int2: assert property (p_int2) else $error("psw not low");

    property p_port;
        @(posedge clk) disable iff (!arst_n)
        (ctrl_r[SSC_REQ_BIT] && !ctrl_r[SSC_PORT_BIT]) |-> !serial_port_avail;
    endproperty
    a_port: assert property (p_port) else $error("port open");

    property p_clk;
        @(posedge clk) disable iff (!arst_n)
        (sleeping && !ctrl_r[SSC_CLK_BIT]) |-> clock_out_pin;
    endproperty
    a_clk: assert property (p_clk) else $error("clock_out_pin low");

    property p_count;
        @(posedge clk) disable iff (!arst_n)
        (st_r == SSC_PRESLEEP && cnt_r != '0 && !tick128 && st_nxt
            == SSC_PRESLEEP) |=> $stable(cnt_r);
    endproperty
    a_count: assert property (p_count) else $error("count w/o tick");

    property p_extra;
        @(posedge clk) disable iff (!arst_n)
        s_quiet_entry |-> $past(tick256);
    endproperty
    a_extra: assert property (p_extra) else $error("extra skipped");
endmodule : ssc_sleep_ctrl

// ===== design/ssc_tick_gen.sv
// Divider chain giving single-cycle 256 Hz and 128 Hz ticks
module ssc_tick_gen
    import ssc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Ticks
    output logic tick256,
    output logic tick128
);
    localparam logic [SSC_DIV_W-1:0] DIV_LAST =
        SSC_DIV_W'(SSC_DIV256_CYC - 1);
    logic [SSC_DIV_W-1:0] cnt_r;
    logic [SSC_DIV_W-1:0] cnt_nxt;
    logic half_r;
    logic half_nxt;
    logic t256_nxt;
    logic t128_nxt;

    always_comb
    begin
        t256_nxt = (cnt_r == DIV_LAST);
        cnt_nxt = t256_nxt ? '0 : cnt_r + 1'b1;
        half_nxt = t256_nxt ? ~half_r : half_r;
        t128_nxt = t256_nxt & half_r;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_r <= '0;
            half_r <= 1'b0;
            tick256 <= 1'b0;
            tick128 <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            half_r <= half_nxt;
            tick256 <= t256_nxt;
            tick128 <= t128_nxt;
        end
    end
endmodule : ssc_tick_gen

// ===== testbench/ssc_host_model.sv
// Host-side wire model with pull-ups on the open-drain pins
module ssc_host_model
(
    // Pin drivers from the device
    input wire logic pg_o,
    input wire logic pg_oe,
    input wire logic psw_o,
    input wire logic psw_oe,
    // Levels seen by the host
    output logic pg_wire,
    output logic psw_wire
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released line rises to the pull-up level
    assign pg_wire = pg_oe ? pg_o : 1'b1;
    assign psw_wire = psw_oe ? psw_o : 1'b1;
endmodule : ssc_host_model

// ===== testbench/test_sleep_state_controller.sv
// Self-checking bench for the sleep state controller
module test_sleep_state_controller
    import ssc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, arst_n, reg_wr, counters_run, wake_armed, any_flag, irq;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, c;
    logic out1_val, out2_val, clk_out_val, pg_o, pg_oe, psw_o, psw_oe;
    logic clock_out_pin, serial_port_avail, sleeping, pg_wire, psw_wire;
    int failures = 0;
    int checked = 0;
    int cycles = 0;

    ssc_sleep_ctrl dut_u (.clk(clk), .arst_n(arst_n), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .counters_run(counters_run), .wake_armed(wake_armed),
        .any_flag(any_flag), .irq(irq), .out1_val(out1_val),
        .out2_val(out2_val), .clk_out_val(clk_out_val),
        .power_good_int_pin_o(pg_o), .power_good_int_pin_oe(pg_oe),
        .power_switch_int_pin_o(psw_o), .power_switch_int_pin_oe(psw_oe),
        .clock_out_pin(clock_out_pin), .serial_port_avail(serial_port_avail),
        .sleeping(sleeping));

    ssc_host_model host_u (.pg_o(pg_o), .pg_oe(pg_oe), .psw_o(psw_o),
        .psw_oe(psw_oe), .pg_wire(pg_wire), .psw_wire(psw_wire));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic final_report();
        $display("Checks %0d, failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 10000)
        begin
            failures++;
            final_report();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] exp);
        reg_addr = SSC_SLEEP_CONTROL_OFS;
        @(negedge clk);
        chk(reg_rdata, exp);
    endtask : rd

    // Bounded wait for the sleep flag to reach a level
    task automatic wait_sleep(input logic e, input int n);
        for (int k = 0; k < n && sleeping !== e; k++)
            @(negedge clk);
        chk({7'h00, sleeping}, {7'h00, e});
    endtask : wait_sleep

    // Pin levels expected from control value and sleep state
    function automatic logic [3:0] exp_pins(logic [7:0] r, logic s);
        logic pg, psw, ck, av;
        pg = (s && !r[SSC_INT1_BIT]) ? 1'b1 : out1_val;
        psw = (s && !r[SSC_INT2_BIT]) ? 1'b0 : out2_val;
        ck = (r[SSC_REQ_BIT] && !r[SSC_CLK_BIT]) ? 1'b1 : clk_out_val;
        av = !(r[SSC_REQ_BIT] && !r[SSC_PORT_BIT]);
        return {pg, psw, ck, av};
    endfunction : exp_pins

    task automatic chk_pins(input logic [7:0] r, input logic s);
        chk({4'h0, pg_wire, psw_wire, clock_out_pin, serial_port_avail},
            {4'h0, exp_pins(r, s)});
    endtask : chk_pins

    task automatic wake(input logic [7:0] r);
        irq = 1'b1;
        @(negedge clk);
        irq = 1'b0;
        chk({7'h00, sleeping}, 8'h00);
        chk_pins(r & 8'h7f, 1'b0);
        rd(r & 8'h7f);
    endtask : wake

    initial
    begin
        arst_n = 1'b0;
        reg_wr = 1'b0;
        reg_addr = SSC_SLEEP_CONTROL_OFS;
        reg_wdata = 8'h00;
        {counters_run, wake_armed, any_flag, irq} = 4'hc;
        {out1_val, out2_val, clk_out_val} = 3'h6;
        c = 8'($urandom(32'h0513));
        repeat (5) @(negedge clk);
        chk({3'h0, pg_oe, psw_oe, clock_out_pin, serial_port_avail,
            sleeping}, 8'h06);
        arst_n = 1'b1;
        rd(SSC_SLEEP_CONTROL_RST);
        wr(8'h16, 8'hff);
        chk(reg_rdata, 8'h00);
        rd(SSC_SLEEP_CONTROL_RST);
        // Every precondition combination, only one accepted
        for (int i = 0; i < 8; i++)
        begin
            {counters_run, wake_armed, any_flag} = i[2:0];
            wr(SSC_SLEEP_CONTROL_OFS, 8'hf8);
            rd((i == 6) ? 8'hf8 : 8'h78);
            wait_sleep(i == 6, 4);
            if (i == 6)
                wake(8'hf8);
            wr(SSC_SLEEP_CONTROL_OFS, 8'h00);
        end
        {counters_run, wake_armed, any_flag} = 3'h6;
        // Random sleep pin settings and pin logic levels
        repeat (12)
        begin
            c = (8'($urandom) & 8'h68) | 8'h90;
            wr(SSC_SLEEP_CONTROL_OFS, c);
            wait_sleep(1'b1, 4);
            repeat (4)
            begin
                {out1_val, out2_val, clk_out_val} = 3'($urandom);
                @(negedge clk);
                chk_pins(c, 1'b1);
            end
            wake(c);
        end
        // Sleep still pending after 1000 cycles: int2 set, port off; then delay 7 with port on
        clk_out_val = 1'b0;
        c = 8'ha0;
        wr(SSC_SLEEP_CONTROL_OFS, c);
        repeat (1000) @(negedge clk);
        chk({7'h00, sleeping}, 8'h00);
        chk_pins(c, 1'b0);
        wr(SSC_SLEEP_CONTROL_OFS, 8'h00);
        chk_pins(8'h00, 1'b0);
        c = 8'h9f;
        wr(SSC_SLEEP_CONTROL_OFS, c);
        repeat (1000) @(negedge clk);
        chk({7'h00, sleeping}, 8'h00);
        chk_pins(c, 1'b0);
        wr(SSC_SLEEP_CONTROL_OFS, 8'h00);
        wait_sleep(1'b0, 1);
        final_report();
    end
endmodule : test_sleep_state_controller
